// file: bench/pmic_top_regs_props.sv
/*
 concurrent checks on the top system register group ports.
 assumes zero-wait single word transfers and a bind from this file.
*/
`timescale 1ns/1ns
module pmic_top_regs_props #(
    parameter int NUM_OUTPUTS = 4
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // reset, active low
    input wire logic ce, // clock enable
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic hready, // bus ready in
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic chip_enable, // chip enable pin
    input wire logic undervoltage_in, // supply low
    input wire logic [NUM_OUTPUTS-1:0] general_purpose_input, // enable pins
    input wire logic [NUM_OUTPUTS-1:0] output_enable, // regulator enables
    input wire logic [NUM_OUTPUTS-1:0] output_low_power // low-power selects
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_any;
        hsel && hready && htrans[1] && ce && !hwrite;
    endsequence
    sequence s_rd(logic [31:0] a);
        s_rd_any ##0 (haddr == a);
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_softrst_reads_zero: assert property (s_rd(32'h0) |=> hrdata == 32'h0)
        else $error("soft reset register read nonzero");
    a_unmapped_zero: assert property (s_rd(32'h1C) |=> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    a_upper_bits_zero: assert property (s_rd_any |=> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_status_width: assert property (s_rd(32'h14) |=> hrdata[31:4] == 28'h0)
        else $error("status reserved bits set");
    a_flags_width: assert property (s_rd(32'hC) |=> hrdata[31:5] == 27'h0)
        else $error("flag reserved bits set");
    a_gpi_first_out: assert property (general_purpose_input[0] [*8] |=> output_enable[0])
        else $error("output one not enabled by its pin");
    a_gpi_last_out: assert property (general_purpose_input[3] [*8] |=> output_enable[3])
        else $error("output four not enabled by its pin");
    a_ce_low_default: assert property ((!chip_enable) [*8] |=> output_low_power == '0)
        else $error("low power kept while chip disabled");
    a_uv_default: assert property (undervoltage_in [*8] |=> !(|output_low_power))
        else $error("low power kept under undervoltage");
endmodule

bind pmic_top_regs pmic_top_regs_props #(.NUM_OUTPUTS(NUM_OUTPUTS)) props_u (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chip_enable(chip_enable),
    .undervoltage_in(undervoltage_in), .general_purpose_input(general_purpose_input),
    .output_enable(output_enable), .output_low_power(output_low_power)
);

// file: bench/tb.sv
/*
 self-checking bench for the top system register group.
 assumes the design package, cfg header and checker are compiled first.
*/
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] A_SRC = 32'h4, A_SRCM = 32'h8, A_FLG = 32'hC;
    localparam logic [31:0] A_SYSM = 32'h10, A_STAT = 32'h14, A_OEN = 32'h18;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, reg_irq = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [1:0] htrans = 2'h0;
    logic [4:0] cond = 5'h00;
    logic [3:0] gpi = 4'h0;
    logic ce = 1'b1, rd_pend = 1'b0;
    logic [2:0] good = 3'h7; // supply ok, chip enable, thermal ok
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq_n;
    wire logic [3:0] oen, olp;
    int mismatches = 0, n_compared = 0, cycles = 0, b;
    int bits[5] = '{4, 2, 1, 0, 3};
    logic [31:0] expq[$];
    string nameq[$];

    pmic_top_regs #(.NUM_OUTPUTS(4)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .regulator_irq(reg_irq),
        .wdog_reset_input_n(~cond[4]), .undervoltage_in(cond[3]),
        .thermal_shutdown_in(cond[2]), .temp_high_warn_in(cond[1]),
        .temp_low_warn_in(cond[0]), .interface_supply_ok(good[0]), .chip_enable(good[1]),
        .thermal_ok_signal(good[2]), .general_purpose_input(gpi), .output_enable(oen),
        .output_low_power(olp), .interrupt_output_n(irq_n)
    );

    initial begin
        forever #5 hclk = ~hclk;
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // read data are compared in the data phase against the oldest note
    always @(posedge hclk) begin
        if (rd_pend) check(nameq.pop_front(), hrdata, expq.pop_front());
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic bus(input logic w, input logic [31:0] a, d, exp, input string nm);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        if (!w) begin
            expq.push_back(exp);
            nameq.push_back(nm);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, 32'h0, "");
    endtask

    task automatic rd(input logic [31:0] a, exp, input string nm);
        bus(1'b0, a, 32'h0, exp, nm);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic set_cond(input logic [4:0] v);
        @(posedge hclk);
        cond <= v;
    endtask

    initial begin
        void'($urandom(585));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        wait_cyc(6);
        rd(32'h0, 32'h0, "soft_reset_control");
        rd(A_SRC, 32'h0, "interrupt_source");
        rd(A_SRCM, 32'h2, "interrupt_source_mask");
        rd(A_FLG, 32'h0, "system_interrupt_flags");
        rd(A_SYSM, 32'h13, "system_interrupt_mask");
        rd(A_STAT, 32'h0, "system_status");
        rd(A_OEN, 32'h0, "output_enable_control");
        rd(32'h1C, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wr(A_SYSM, r);
            rd(A_SYSM, r & 32'h1F, "system_interrupt_mask");
            wr(A_SRCM, r);
            rd(A_SRCM, r & 32'h3, "interrupt_source_mask");
            wr(A_OEN, r);
            rd(A_OEN, r & 32'hFF, "output_enable_control");
            wait_cyc(2);
            check("output_enable", oen, {r[6], r[4], r[2], r[0]});
            check("output_low_power", olp, {r[7], r[5], r[3], r[1]});
            wr(A_STAT, r);
            rd(A_STAT, 32'h0, "system_status");
        end
        // a latched flag must survive the soft reset
        set_cond(5'h01);
        wait_cyc(8);
        wr(A_OEN, 32'hFF);
        wr(32'h0, 32'h1);
        wait_cyc(2);
        check("output_low_power", olp, 32'h0);
        rd(32'h0, 32'h0, "soft_reset_control");
        rd(A_SYSM, 32'h13, "system_interrupt_mask");
        rd(A_OEN, 32'h0, "output_enable_control");
        rd(A_FLG, 32'h1, "system_interrupt_flags");
        set_cond(5'h00);
        rd(A_FLG, 32'h0, "system_interrupt_flags");
        wr(A_SRCM, 32'h2);
        foreach (bits[k]) begin
            b = bits[k];
            wr(A_SYSM, 32'h0);
            set_cond(5'(1 << b));
            wait_cyc(8);
            check("interrupt_output_n", irq_n, 32'h0);
            rd(A_SRC, 32'h1, "interrupt_source");
            rd(A_STAT, (1 << b) & 32'hF, "system_status");
            rd(A_FLG, 1 << b, "system_interrupt_flags");
            set_cond(5'h00);
            rd(A_FLG, 32'h0, "system_interrupt_flags");
            wait_cyc(2);
            check("interrupt_output_n", irq_n, 32'h1);
        end
        wr(A_SYSM, 32'h1F);
        set_cond(5'h01);
        wait_cyc(8);
        check("interrupt_output_n", irq_n, 32'h1);
        rd(A_SRC, 32'h0, "interrupt_source");
        rd(A_FLG, 32'h1, "system_interrupt_flags");
        set_cond(5'h00);
        wr(A_SRCM, 32'h0);
        reg_irq <= 1'b1;
        wait_cyc(3);
        check("interrupt_output_n", irq_n, 32'h0);
        rd(A_SRC, 32'h2, "interrupt_source");
        wr(A_SRCM, 32'h2);
        wait_cyc(2);
        check("interrupt_output_n", irq_n, 32'h1);
        reg_irq <= 1'b0;
        wr(A_OEN, 32'h0);
        r = $urandom;
        gpi <= r[3:0] | 4'h9;
        wait_cyc(10);
        check("output_enable", oen, r[3:0] | 4'h9);
        // each good input in turn drops and restores the configuration defaults
        for (int j = 0; j < 3; j++) begin
            wr(A_OEN, 32'hAA);
            good[j] <= 1'b0;
            wait_cyc(10);
            check("output_low_power", olp, 32'h0);
            good[j] <= 1'b1;
            wait_cyc(8);
            rd(A_OEN, 32'h0, "output_enable_control");
        end
        // clock enable low freezes the enable path
        ce <= 1'b0;
        gpi <= 4'h0;
        wait_cyc(10);
        check("output_enable", oen, r[3:0] | 4'h9);
        ce <= 1'b1;
        wait_cyc(8);
        check("output_enable", oen, 32'h0);
        print_verdict();
    end
endmodule

// file: design/event_sync.sv
/*
 three-flop synchroniser with agreement filter for WIDTH pin inputs.
 assumes an asynchronous pin and a shared clock enable.
*/
`timescale 1ns/1ns
module event_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [WIDTH-1:0] pin, // raw async inputs
    output logic [WIDTH-1:0] level, // filtered level
    output logic [WIDTH-1:0] rise // one-cycle pulse on rising level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    initial begin
        if (WIDTH < 1) $error("event_sync width must be at least 1");
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    level[i] <= 1'b0;
                    rise[i] <= 1'b0;
                end else if (ce) begin
                    // change counts only once second and third agree
                    rise[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level[i];
                    if (s2_q[i] == s3_q[i]) begin
                        level[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// file: design/pmic_top_cfg.svh
/*
 constants for the top system register group: offsets, field positions,
 reset values and masks. assumes byte-addressed word-aligned ahb access.
*/
`ifndef PMIC_TOP_CFG_SVH
`define PMIC_TOP_CFG_SVH

`define REG_IDX_SOFT_RESET 3'h0
`define REG_IDX_INT_SOURCE 3'h1
`define REG_IDX_INT_SOURCE_MASK 3'h2
`define REG_IDX_SYS_FLAGS 3'h3
`define REG_IDX_SYS_MASK 3'h4
`define REG_IDX_SYS_STATUS 3'h5
`define REG_IDX_OUT_ENABLE 3'h6
`define REG_IDX_LAST 3'h6

`define SRC_BIT_REGULATOR 1
`define SRC_BIT_SYSTEM 0
`define FLAG_BIT_WDOG 4
`define FLAG_BIT_UNDERVOLTAGE_STATUS 3
`define FLAG_BIT_THERMAL_SHUTDOWN_STATUS 2
`define FLAG_BIT_TEMP_HIGH 1
`define FLAG_BIT_TEMP_LOW 0

`define RST_INT_SOURCE_MASK 2'h2
`define RST_SYS_MASK 5'h13
`define RST_OUT_ENABLE 8'h00
`define SOFT_RESET_BIT 0

`endif

// file: design/pmic_top_pkg.sv
/*
 types for the top system register group.
 assumes the cfg header for numeric constants.
*/
package pmic_top_pkg;
    typedef struct packed {
        logic wdog;
        logic undervoltage_status;
        logic thermal_shutdown_status;
        logic temp_high;
        logic temp_low;
    } sys_flags_t;

    typedef struct packed {
        logic undervoltage_status;
        logic thermal_shutdown_status;
        logic temp_high;
        logic temp_low;
    } sys_status_t;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] low_power;
    } reg_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DATA = 2'b01
    } bus_state_t;
endpackage

// file: design/pmic_top_regs.sv
/*
 top system register group of a multi-output regulator controller: soft
 reset, interrupt source aggregation, latched system flags, live status,
 output enables with low-power bits. ahb-lite slave, zero wait states.
 assumes analog condition inputs are asynchronous pins.
*/
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pmic_top_cfg.svh"

module pmic_top_regs
    import pmic_top_pkg::*;
#(
    parameter int NUM_OUTPUTS = 4
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // power-on reset, active low
    input wire logic ce, // clock enable
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    input wire logic regulator_irq, // regulator section pending, same clock
    input wire logic wdog_reset_input_n, // watchdog reset pin, active low
    input wire logic undervoltage_in, // supply below lockout threshold
    input wire logic thermal_shutdown_in, // junction above 165 C
    input wire logic temp_high_warn_in, // junction above 140 C
    input wire logic temp_low_warn_in, // junction above 120 C
    input wire logic interface_supply_ok, // interface supply valid
    input wire logic chip_enable, // chip enable pin
    input wire logic thermal_ok_signal, // thermal ok
    input wire logic [NUM_OUTPUTS-1:0] general_purpose_input, // per-output enable pins
    output logic [NUM_OUTPUTS-1:0] output_enable, // regulator enables
    output logic [NUM_OUTPUTS-1:0] output_low_power, // low-power mode selects
    output logic interrupt_output_n // interrupt, active low
);
    localparam int NPIN = 5 + 3 + NUM_OUTPUTS;

    initial begin
        if (NUM_OUTPUTS != 4) $error("pmic_top_regs supports exactly four outputs");
    end

    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        reg_index = addr[4:2];
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        mapped = (addr[31:5] == 27'h0) && (addr[4:2] <= `REG_IDX_LAST);
    endfunction

    // pin synchronisation
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_rise;

    assign pin_raw = {general_purpose_input, thermal_ok_signal, chip_enable,
                      interface_supply_ok, ~wdog_reset_input_n, undervoltage_in,
                      thermal_shutdown_in, temp_high_warn_in, temp_low_warn_in};

    event_sync #(
        .WIDTH(NPIN)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    sys_status_t status;
    sys_flags_t flag_events;
    logic [NUM_OUTPUTS-1:0] gpi_lvl;
    logic cfg_reset;

    assign status = sys_status_t'(pin_lvl[3:0]);
    assign flag_events = sys_flags_t'(pin_rise[4:0]);
    assign gpi_lvl = pin_lvl[NPIN-1 -: NUM_OUTPUTS];

    // bus address phase capture
    bus_state_t bus_q;
    logic [2:0] idx_q;
    logic wr_q;
    logic hit_q;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q <= BUS_IDLE;
            idx_q <= 3'h0;
            wr_q <= 1'b0;
            hit_q <= 1'b0;
        end else if (ce) begin
            bus_q <= take ? BUS_DATA : BUS_IDLE;
            if (take) begin
                idx_q <= reg_index(haddr);
                wr_q <= hwrite;
                hit_q <= mapped(haddr);
            end
        end
    end

    logic wr_en;
    logic rd_take;

    always_comb begin
        wr_en = 1'b0;
        case (bus_q)
            BUS_IDLE: wr_en = 1'b0;
            BUS_DATA: wr_en = wr_q && hit_q;
            default: wr_en = 1'b0;
        endcase
    end

    assign rd_take = take && !hwrite && mapped(haddr);

    // soft reset pulse, self-clearing
    logic soft_reset_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_reset_q <= 1'b0;
        end else if (ce) begin
            soft_reset_q <= wr_en && (idx_q == `REG_IDX_SOFT_RESET)
                            && hwdata[`SOFT_RESET_BIT];
        end
    end

    // configuration-class reset, excludes the flag register
    assign cfg_reset = soft_reset_q || status.undervoltage_status || !pin_lvl[5]
                       || !pin_lvl[6] || !pin_lvl[7];

    logic [1:0] src_mask_q;
    logic [4:0] sys_mask_q;
    reg_out_t out_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_mask_q <= `RST_INT_SOURCE_MASK;
        end else if (ce) begin
            if (cfg_reset) begin
                src_mask_q <= `RST_INT_SOURCE_MASK;
            end else if (wr_en && idx_q == `REG_IDX_INT_SOURCE_MASK) begin
                src_mask_q <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_mask_q <= `RST_SYS_MASK;
        end else if (ce) begin
            if (cfg_reset) begin
                sys_mask_q <= `RST_SYS_MASK;
            end else if (wr_en && idx_q == `REG_IDX_SYS_MASK) begin
                sys_mask_q <= hwdata[4:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_q.enable[g] <= 1'b0;
                    out_q.low_power[g] <= 1'b0;
                end else if (ce) begin
                    if (cfg_reset) begin
                        out_q.enable[g] <= 1'b0;
                        out_q.low_power[g] <= 1'b0;
                    end else if (wr_en && idx_q == `REG_IDX_OUT_ENABLE) begin
                        out_q.enable[g] <= hwdata[2*g];
                        out_q.low_power[g] <= hwdata[2*g+1];
                    end
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    output_enable[g] <= 1'b0;
                    output_low_power[g] <= 1'b0;
                end else if (ce) begin
                    output_enable[g] <= out_q.enable[g] || gpi_lvl[g];
                    output_low_power[g] <= out_q.low_power[g];
                end
            end
        end
    endgenerate

    // latched flags: power-on reset only, read clears, set beats clear
    logic [4:0] flags_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 5'h00;
        end else if (ce) begin
            flags_q <= (rd_take && reg_index(haddr) == `REG_IDX_SYS_FLAGS)
                       ? 5'h00 : flags_q;
            if (flag_events.wdog) flags_q[`FLAG_BIT_WDOG] <= 1'b1;
            if (flag_events.undervoltage_status) flags_q[`FLAG_BIT_UNDERVOLTAGE_STATUS] <= 1'b1;
            if (flag_events.thermal_shutdown_status) flags_q[`FLAG_BIT_THERMAL_SHUTDOWN_STATUS] <= 1'b1;
            if (flag_events.temp_high) flags_q[`FLAG_BIT_TEMP_HIGH] <= 1'b1;
            if (flag_events.temp_low) flags_q[`FLAG_BIT_TEMP_LOW] <= 1'b1;
        end
    end

    logic [1:0] source;
    assign source[`SRC_BIT_SYSTEM] = |(flags_q & ~sys_mask_q);
    assign source[`SRC_BIT_REGULATOR] = regulator_irq;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_output_n <= 1'b1;
        end else if (ce) begin
            interrupt_output_n <= !(|(source & ~src_mask_q));
        end
    end

    // read data registered at address phase
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (reg_index(haddr))
            `REG_IDX_SOFT_RESET: rd_byte = 8'h00;
            `REG_IDX_INT_SOURCE: rd_byte = {6'h00, source};
            `REG_IDX_INT_SOURCE_MASK: rd_byte = {6'h00, src_mask_q};
            `REG_IDX_SYS_FLAGS: rd_byte = {3'h0, flags_q};
            `REG_IDX_SYS_MASK: rd_byte = {3'h0, sys_mask_q};
            `REG_IDX_SYS_STATUS: rd_byte = {4'h0, status};
            `REG_IDX_OUT_ENABLE: rd_byte = {out_q.low_power[3], out_q.enable[3],
                                            out_q.low_power[2], out_q.enable[2],
                                            out_q.low_power[1], out_q.enable[1],
                                            out_q.low_power[0], out_q.enable[0]};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce) begin
            if (rd_take) begin
                hrdata <= {24'h000000, rd_byte};
            end else if (take) begin
                hrdata <= 32'h00000000;
            end
        end
    end
endmodule
